/* File: src/csc_cal_ctrl.sv */
// calibration lock, passcode, step, note and reference value control
// ---------------------------------------------------------------
// Overview of operation
// - lock changes only with matching stored passcode
// - lock state kept in non-volatile image
// - numeric 0/1 accepted as off/on
// - passcode up to 12 chars, must match
// - factory image: locked, factory passcode
// - instrument reset keeps lock state
// - lock query answers 1 locked, 0 unlocked
// - step 0 to 84, query returns it
// - note up to 40 chars, kept non-volatile
// - note stored only while unlocked
// - note survives power loss and reset
// - note query quoted, empty gives two quotes
// - value command records reference level
// - instrument reset keeps reference value
// - value query returns held value
// - adjustment only while unlocked
// ---------------------------------------------------------------
`timescale 1ns/1ps
module csc_cal_ctrl
   import csc_pkg::*;
#(
   // arbitrary neutral factory passcode, "FACTORYCODE1"
   parameter logic [95:0] FACTORY_CODE = 96'h46_41_43_54_4F_52_59_43_4F_44_45_31
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  cmd_valid_i,
   output logic                       cmd_ready_o,
   input  wire csc_pkg::csc_op_t      cmd_op_i,
   input  wire logic                  arg_is_kw_i,
   input  wire logic [31:0]           arg_num_i,
   input  wire logic [95:0]           code_i,
   input  wire logic [3:0]            code_len_i,
   input  wire logic [319:0]          note_i,
   input  wire logic [5:0]            note_len_i,
   output logic                       rsp_valid_o,
   input  wire logic                  rsp_ready_i,
   output logic [7:0]                 rsp_data_o,
   output logic                       rsp_last_o,
   output logic                       err_o,
   output logic                       adjust_o,
   output logic                       locked_o,
   output logic [6:0]                 step_o,
   output logic [31:0]                cal_value_o,
   input  wire logic                  nv_valid_i,
   input  wire logic                  nv_locked_i,
   input  wire logic [95:0]           nv_code_i,
   input  wire logic [3:0]            nv_code_len_i,
   input  wire logic [31:0]           nv_value_i,
   input  wire logic [319:0]          nv_note_i,
   input  wire logic [5:0]            nv_note_len_i,
   output logic                       nv_wr_o,
   output logic                       nv_locked_o,
   output logic [95:0]                nv_code_o,
   output logic [3:0]                 nv_code_len_o,
   output logic [31:0]                nv_value_o,
   output logic [319:0]               nv_note_o,
   output logic [5:0]                 nv_note_len_o
);
   import csc_pkg::*;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic code_eq(input logic [95:0] a, input logic [3:0] alen,
                                    input logic [95:0] b, input logic [3:0] blen);
      logic eq;
      eq = (alen == blen);
      for (int i = 0; i < CODE_CHARS; i++) begin
         if (i < 32'(alen) && a[95-i*8 -: 8] != b[95-i*8 -: 8]) eq = 1'b0;
      end
      return eq;
   endfunction : code_eq

   function automatic logic bool_ok(input logic [31:0] v);
      return (v == BOOL_OFF) || (v == BOOL_ON);
   endfunction : bool_ok

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   csc_state_t  state_reg;
   logic        load_done_reg;
   logic        locked_reg;
   logic [95:0] code_reg;
   logic [3:0]  code_len_reg;
   logic [6:0]  step_reg;
   logic [31:0] value_reg;
   logic [7:0]  rsp_data_reg;
   logic [7:0]  sbuf_reg [4];
   logic [2:0]  slen_reg;
   logic [5:0]  idx_reg;
   logic        err_reg;
   logic        adjust_reg;
   logic        nv_wr_reg;

   logic        accept;
   logic        code_match;
   logic        note_wr;
   logic [5:0]  note_len;
   logic [7:0]  note_rd;
   logic [7:0]  q_bytes [4];
   logic [2:0]  q_len;
   logic        lock_do, code_do, step_do, note_do, val_do, adj_do, bad;

   assign cmd_ready_o = load_done_reg && (state_reg == ST_IDLE);
   assign accept      = cmd_valid_i && cmd_ready_o;
   assign code_match  = code_eq(code_i, code_len_i, code_reg, code_len_reg);

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   always_comb begin
      lock_do = accept && cmd_op_i == OP_LOCK_SET && code_match && bool_ok(arg_num_i);
      code_do = accept && cmd_op_i == OP_CODE_SET && !locked_reg
                && code_len_i != 4'h0 && 32'(code_len_i) <= CODE_CHARS;
      step_do = accept && cmd_op_i == OP_STEP_SET && arg_num_i <= 32'(STEP_MAX);
      note_do = accept && cmd_op_i == OP_NOTE_SET && !locked_reg
                && 32'(note_len_i) <= NOTE_CHARS;
      val_do  = accept && cmd_op_i == OP_VAL_SET;
      adj_do  = accept && cmd_op_i == OP_ADJUST && !locked_reg;
      bad     = accept && ((cmd_op_i == OP_LOCK_SET && !lock_do)
                || (cmd_op_i == OP_CODE_SET && !code_do)
                || (cmd_op_i == OP_STEP_SET && !step_do)
                || (cmd_op_i == OP_NOTE_SET && !note_do)
                || (cmd_op_i == OP_ADJUST && !adj_do));
   end

   // ---------------------------------------------------------------
   // persistent settings
   // ---------------------------------------------------------------
   // image caught after reset release; blank image gives factory values
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         load_done_reg <= 1'b0;
         locked_reg    <= LOCK_FACTORY;
         code_reg      <= '0;
         code_len_reg  <= 4'h0;
         value_reg     <= VALUE_RST;
      end else if (!load_done_reg) begin
         load_done_reg <= 1'b1;
         locked_reg    <= nv_valid_i ? nv_locked_i : LOCK_FACTORY;
         code_reg      <= nv_valid_i ? nv_code_i : FACTORY_CODE;
         code_len_reg  <= nv_valid_i ? nv_code_len_i : 4'(CODE_CHARS);
         value_reg     <= nv_valid_i ? nv_value_i : VALUE_RST;
      end else begin
         // numeric and keyword forms share one encoding
         if (lock_do) locked_reg <= arg_num_i[0];
         if (code_do) begin
            code_reg     <= code_i;
            code_len_reg <= code_len_i;
         end
         if (val_do) value_reg <= arg_num_i;
      end
   end

   // step is volatile; instrument reset returns it to the first step
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         step_reg <= STEP_RST;
      end else if (step_do) begin
         step_reg <= arg_num_i[6:0];
      end else if (accept && cmd_op_i == OP_INST_RST) begin
         step_reg <= STEP_RST;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         err_reg    <= 1'b0;
         adjust_reg <= 1'b0;
         nv_wr_reg  <= 1'b0;
      end else begin
         err_reg    <= bad;
         adjust_reg <= adj_do;
         nv_wr_reg  <= lock_do || code_do || note_do || val_do;
      end
   end

   // ---------------------------------------------------------------
   // note store
   // ---------------------------------------------------------------
   // note loaded from image, written only by accepted note command
   assign note_wr = !load_done_reg ? 1'b1 : note_do;

   csc_note_store #(.DEPTH(NOTE_CHARS), .LEN_W(6)) u_note (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .wr_i      (note_wr),
      .wr_note_i (!load_done_reg ? (nv_valid_i ? nv_note_i : '0) : note_i),
      .wr_len_i  (!load_done_reg ? (nv_valid_i ? nv_note_len_i : 6'h00) : note_len_i),
      .rd_idx_i  (idx_reg),
      .rd_data_o (note_rd),
      .len_o     (note_len),
      .flat_o    (nv_note_o)
   );

   // ---------------------------------------------------------------
   // responses
   // ---------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 4; i++) q_bytes[i] = 8'h00;
      q_len = 3'h1;
      unique case (cmd_op_i)
         OP_LOCK_QRY: q_bytes[0] = locked_reg ? CH_ONE : CH_ZERO;
         OP_STEP_QRY: begin
            if (step_reg >= 7'h0A) begin
               q_bytes[0] = CH_ZERO + 8'(step_reg / 7'h0A);
               q_bytes[1] = CH_ZERO + 8'(step_reg % 7'h0A);
               q_len      = 3'h2;
            end else begin
               q_bytes[0] = CH_ZERO + 8'(step_reg);
            end
         end
         OP_VAL_QRY: begin
            for (int i = 0; i < 4; i++) q_bytes[i] = value_reg[31-i*8 -: 8];
            q_len = 3'h4;
         end
         OP_ADJUST: begin
            if (adj_do) begin
               q_bytes[0] = CH_PLUS;
               q_bytes[1] = CH_ZERO;
               q_len      = 3'h2;
            end else begin
               q_bytes[0] = CH_ONE;
            end
         end
         default: q_len = 3'h0;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg    <= ST_IDLE;
         idx_reg      <= 6'h00;
         slen_reg     <= 3'h0;
         rsp_data_reg <= 8'h00;
         for (int i = 0; i < 4; i++) sbuf_reg[i] <= 8'h00;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               idx_reg <= 6'h00;
               if (accept && cmd_op_i == OP_NOTE_QRY) begin
                  rsp_data_reg <= CH_QUOTE;
                  state_reg    <= ST_NOTE;
               end else if (accept && q_len != 3'h0) begin
                  sbuf_reg     <= q_bytes;
                  slen_reg     <= q_len;
                  rsp_data_reg <= q_bytes[0];
                  state_reg    <= ST_SHORT;
               end
            end
            ST_SHORT: begin
               if (rsp_ready_i) begin
                  if (rsp_last_o) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     idx_reg      <= idx_reg + 6'h01;
                     rsp_data_reg <= sbuf_reg[idx_reg[1:0] + 2'h1];
                  end
               end
            end
            ST_NOTE: begin
               if (rsp_ready_i) begin
                  if (rsp_last_o) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     idx_reg      <= idx_reg + 6'h01;
                     rsp_data_reg <= (idx_reg == note_len) ? CH_QUOTE : note_rd;
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   assign rsp_valid_o = (state_reg != ST_IDLE);
   assign rsp_last_o  = (state_reg == ST_SHORT && {3'h0, slen_reg} == idx_reg + 6'h01)
                     || (state_reg == ST_NOTE && idx_reg == note_len + 6'h01);
   assign rsp_data_o  = rsp_data_reg;
   assign err_o       = err_reg;
   assign adjust_o    = adjust_reg;
   assign locked_o    = locked_reg;
   assign step_o      = step_reg;
   assign cal_value_o = value_reg;
   assign nv_wr_o       = nv_wr_reg;
   assign nv_locked_o   = locked_reg;
   assign nv_code_o     = code_reg;
   assign nv_code_len_o = code_len_reg;
   assign nv_value_o    = value_reg;
   assign nv_note_len_o = note_len;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_note_qry_empty;
      accept && cmd_op_i == OP_NOTE_QRY && note_len == 6'h00;
   endsequence
   sequence s_two_quotes;
      (rsp_valid_o && rsp_data_o == CH_QUOTE && !rsp_last_o && rsp_ready_i)
      ##1 (rsp_valid_o && rsp_data_o == CH_QUOTE && rsp_last_o);
   endsequence

   AST_LOCK_NEEDS_CODE: assert property (
      load_done_reg && $past(load_done_reg) && $changed(locked_reg)
      |-> $past(accept && cmd_op_i == OP_LOCK_SET && code_match))
      else $error("lock changed without matching passcode");
   AST_BAD_CODE_ERR: assert property (
      accept && cmd_op_i == OP_LOCK_SET && !code_match |=> err_o && $stable(locked_reg))
      else $error("wrong passcode not refused");
   AST_NUMERIC_BOOL: assert property (
      lock_do |=> locked_reg == $past(arg_num_i[0]) && !err_o)
      else $error("lock setting not applied");
   AST_RST_KEEPS: assert property (
      accept && cmd_op_i == OP_INST_RST |=> $stable(locked_reg) && $stable(value_reg)
      && step_reg == STEP_RST)
      else $error("instrument reset disturbed lock or value");
   AST_LOCK_QRY: assert property (
      accept && cmd_op_i == OP_LOCK_QRY
      |=> rsp_valid_o && rsp_last_o && rsp_data_o == (locked_reg ? CH_ONE : CH_ZERO))
      else $error("lock query answer wrong");
   AST_STEP_RANGE: assert property (
      step_reg <= STEP_MAX)
      else $error("step out of range");
   AST_NOTE_LOCKED: assert property (
      accept && cmd_op_i == OP_NOTE_SET && locked_reg |=> err_o && $stable(note_len)
      && $stable(nv_note_o))
      else $error("note changed while locked");
   AST_NOTE_EMPTY: assert property (
      s_note_qry_empty ##1 !rsp_ready_i ##1 rsp_ready_i |-> s_two_quotes)
      else $error("empty note not two quotes");
   AST_ADJ_UNLOCKED: assert property (
      adjust_o |-> $past(accept && cmd_op_i == OP_ADJUST && !locked_reg))
      else $error("adjust while locked");

endmodule : csc_cal_ctrl

/* File: src/csc_note_store.sv */
// character store for the calibration note
`timescale 1ns/1ps
module csc_note_store #(
   parameter int DEPTH = 40,
   parameter int LEN_W = 6
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 wr_i,
   input  wire logic [DEPTH*8-1:0]   wr_note_i,
   input  wire logic [LEN_W-1:0]     wr_len_i,
   input  wire logic [LEN_W-1:0]     rd_idx_i,
   output logic      [7:0]           rd_data_o,
   output logic      [LEN_W-1:0]     len_o,
   output logic      [DEPTH*8-1:0]   flat_o
);
   logic [7:0]       mem_reg [DEPTH];
   logic [LEN_W-1:0] len_reg;

   // length field must be able to count every character slot
   if (DEPTH < 1 || DEPTH >= (1 << LEN_W)) begin : g_bad_depth
      $error("csc_note_store: bad DEPTH");
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         len_reg <= '0;
         for (int i = 0; i < DEPTH; i++) mem_reg[i] <= 8'h00;
      end else if (wr_i) begin
         len_reg <= wr_len_i;
         for (int i = 0; i < DEPTH; i++) mem_reg[i] <= wr_note_i[i*8 +: 8];
      end
   end

   always_comb begin
      rd_data_o = (32'(rd_idx_i) < DEPTH) ? mem_reg[rd_idx_i] : 8'h00;
      for (int i = 0; i < DEPTH; i++) flat_o[i*8 +: 8] = mem_reg[i];
   end

   assign len_o = len_reg;

endmodule : csc_note_store

/* File: src/csc_pkg.sv */
// constants, command codes and state codes for the calibration security control
package csc_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int          CHAR_W     = 8;
   localparam int          CODE_CHARS = 12;
   localparam int          NOTE_CHARS = 40;
   localparam int          NUM_W      = 32;
   localparam logic [6:0]  STEP_MAX   = 7'h54;
   localparam logic [6:0]  STEP_RST   = 7'h00;

   // ---------------------------------------------------------------
   // reset values and boolean argument
   // ---------------------------------------------------------------
   localparam logic        LOCK_FACTORY = 1'b1;
   localparam logic [31:0] VALUE_RST    = 32'h0000_0000;
   localparam logic [31:0] BOOL_OFF     = 32'h0000_0000;
   localparam logic [31:0] BOOL_ON      = 32'h0000_0001;

   // ---------------------------------------------------------------
   // response characters
   // ---------------------------------------------------------------
   localparam logic [7:0]  CH_QUOTE = 8'h22;
   localparam logic [7:0]  CH_PLUS  = 8'h2B;
   localparam logic [7:0]  CH_ZERO  = 8'h30;
   localparam logic [7:0]  CH_ONE   = 8'h31;

   // ---------------------------------------------------------------
   // commands and states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_LOCK_SET = 4'h0,
      OP_CODE_SET = 4'h1,
      OP_LOCK_QRY = 4'h2,
      OP_STEP_SET = 4'h3,
      OP_STEP_QRY = 4'h4,
      OP_NOTE_SET = 4'h5,
      OP_NOTE_QRY = 4'h6,
      OP_VAL_SET  = 4'h7,
      OP_VAL_QRY  = 4'h8,
      OP_ADJUST   = 4'h9,
      OP_INST_RST = 4'hA
   } csc_op_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SHORT = 3'b010,
      ST_NOTE  = 3'b100
   } csc_state_t;

endpackage : csc_pkg

/* File: test/csc_cal_ctrl_bench.sv */
// self-checking bench for the calibration lock, note, step and value control
`timescale 1ns/1ps
`define CHK(nm, e, g) check(nm, 64'(e), 64'(g))
module csc_cal_ctrl_bench;
   import csc_pkg::*;
   // arbitrary passcodes, letter first
   localparam logic [95:0] BENCH_CODE = "BENCHCODE_01";
   localparam logic [95:0] NEW_CODE   = {"NEWCODE", 40'h0};
   localparam logic [319:0] NOTE_AB   = 320'(16'h4241);

   logic clk_i, rst_n_i, cmd_valid_i, cmd_ready_o, arg_is_kw_i, rsp_valid_o, rsp_ready_i;
   logic rsp_last_o, err_o, adjust_o, locked_o, nv_valid_i, nv_locked_i, nv_wr_o, nv_locked_o;
   logic hang;
   csc_op_t        cmd_op_i;
   logic [31:0]    arg_num_i, cal_value_o, nv_value_i, nv_value_o;
   logic [95:0]    code_i, nv_code_i, nv_code_o;
   logic [3:0]     code_len_i, nv_code_len_i, nv_code_len_o;
   logic [319:0]   note_i, nv_note_i, nv_note_o;
   logic [5:0]     note_len_i, nv_note_len_i, nv_note_len_o;
   logic [7:0]     rsp_data_o;
   logic [6:0]     step_o;
   int             miscompares = 0;
   int             n_checks = 0;

   csc_cal_ctrl #(.FACTORY_CODE(BENCH_CODE)) csc_cal_ctrl_inst (
      .clk_i, .rst_n_i, .cmd_valid_i, .cmd_ready_o, .cmd_op_i, .arg_is_kw_i, .arg_num_i,
      .code_i, .code_len_i, .note_i, .note_len_i, .rsp_valid_o, .rsp_ready_i, .rsp_data_o,
      .rsp_last_o, .err_o, .adjust_o, .locked_o, .step_o, .cal_value_o, .nv_valid_i,
      .nv_locked_i, .nv_code_i, .nv_code_len_i, .nv_value_i, .nv_note_i, .nv_note_len_i,
      .nv_wr_o, .nv_locked_o, .nv_code_o, .nv_code_len_o, .nv_value_o, .nv_note_o,
      .nv_note_len_o);

   csc_host_model host_inst (
      .clk_i, .cmd_ready_i(cmd_ready_o), .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o),
      .rsp_last_i(rsp_last_o), .err_i(err_o), .adjust_i(adjust_o), .nv_wr_i(nv_wr_o),
      .cmd_valid_o(cmd_valid_i), .cmd_op_o(cmd_op_i), .arg_is_kw_o(arg_is_kw_i),
      .arg_num_o(arg_num_i), .code_o(code_i), .code_len_o(code_len_i), .note_o(note_i),
      .note_len_o(note_len_i), .rsp_ready_o(rsp_ready_i), .hang_o(hang));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // ---------------------------------------------------------------
   // checking and closing
   // ---------------------------------------------------------------
   task automatic check(input string nm, input logic [63:0] e, input logic [63:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : check

   task automatic wrap_up;
      if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   always @(posedge hang) begin
      miscompares++;
      wrap_up();
   end

   task automatic lock_set(input logic [31:0] v, input logic [95:0] c, input logic [3:0] l);
      host_inst.issue(OP_LOCK_SET, v, c, l, '0, 6'h00);
   endtask : lock_set

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_factory;
      `CHK("locked", 1'b1, locked_o);
      host_inst.query(OP_LOCK_QRY, 0);
      `CHK("lock_qry", {8'h01, CH_ONE}, {8'(host_inst.nb), host_inst.got[7:0]});
      host_inst.query(OP_NOTE_QRY, 0);
      `CHK("empty_note", {8'h02, CH_QUOTE, CH_QUOTE}, {8'(host_inst.nb), host_inst.got[15:0]});
   endtask : t_factory

   task automatic t_lock;
      lock_set(BOOL_OFF, {BENCH_CODE[95:8], "2"}, 4'hC);
      `CHK("bad_code", 2'b11, {host_inst.err_seen, locked_o});
      lock_set(BOOL_OFF, BENCH_CODE, 4'hB);
      `CHK("bad_len", 2'b11, {host_inst.err_seen, locked_o});
      lock_set(32'h0000_0002, BENCH_CODE, 4'hC);
      `CHK("bad_bool", 2'b11, {host_inst.err_seen, locked_o});
      lock_set(BOOL_OFF, BENCH_CODE, 4'hC);
      `CHK("unlock", 4'b0100, {host_inst.err_seen, host_inst.nv_seen, locked_o, nv_locked_o});
      host_inst.query(OP_LOCK_QRY, 0);
      `CHK("lock_qry0", CH_ZERO, host_inst.got[7:0]);
   endtask : t_lock

   task automatic t_note;
      host_inst.issue(OP_NOTE_SET, '0, '0, 4'h0, NOTE_AB, 6'h02);
      `CHK("note_set", 2'b01, {host_inst.err_seen, host_inst.nv_seen});
      host_inst.query(OP_NOTE_QRY, 3);
      `CHK("note_qry", {8'h04, CH_QUOTE, 16'h4142, CH_QUOTE},
           {8'(host_inst.nb), host_inst.got[31:0]});
      host_inst.issue(OP_NOTE_SET, '0, '0, 4'h0, '1, 6'h29);
      `CHK("note_long", 1'b1, host_inst.err_seen);
      lock_set(BOOL_ON, BENCH_CODE, 4'hC);
      `CHK("relock", 1'b1, locked_o);
      host_inst.issue(OP_NOTE_SET, '0, '0, 4'h0, 320'(16'h5958), 6'h02);
      `CHK("note_locked", 1'b1, host_inst.err_seen);
      host_inst.query(OP_NOTE_QRY, 0);
      `CHK("note_kept", {CH_QUOTE, 16'h4142, CH_QUOTE}, host_inst.got[31:0]);
   endtask : t_note

   task automatic t_step_value;
      host_inst.issue(OP_STEP_SET, 32'h0000_0054, '0, 4'h0, '0, 6'h00);
      host_inst.query(OP_STEP_QRY, 0);
      `CHK("step84", {8'h02, 16'h3834}, {8'(host_inst.nb), host_inst.got[15:0]});
      host_inst.issue(OP_STEP_SET, 32'h0000_0055, '0, 4'h0, '0, 6'h00);
      `CHK("step85", {1'b1, STEP_MAX}, {host_inst.err_seen, step_o});
      host_inst.issue(OP_VAL_SET, 32'h1234_5678, '0, 4'h0, '0, 6'h00);
      `CHK("value", 32'h1234_5678, cal_value_o);
      host_inst.query(OP_VAL_QRY, 0);
      `CHK("val_qry", {8'h04, 32'h1234_5678}, {8'(host_inst.nb), host_inst.got[31:0]});
      host_inst.issue(OP_INST_RST, '0, '0, 4'h0, '0, 6'h00);
      `CHK("rst_lock", {1'b1, STEP_RST}, {locked_o, step_o});
      `CHK("rst_value", 32'h1234_5678, cal_value_o);
   endtask : t_step_value

   task automatic t_adjust_code;
      host_inst.query(OP_ADJUST, 0);
      `CHK("adj_locked", {2'b10, CH_ONE}, {host_inst.err_seen, host_inst.adj_seen,
           host_inst.got[7:0]});
      lock_set(BOOL_OFF, BENCH_CODE, 4'hC);
      host_inst.query(OP_ADJUST, 0);
      `CHK("adj_open", {2'b01, CH_PLUS, CH_ZERO}, {host_inst.err_seen, host_inst.adj_seen,
           host_inst.got[15:0]});
      host_inst.issue(OP_CODE_SET, '0, NEW_CODE, 4'h7, '0, 6'h00);
      lock_set(BOOL_ON, NEW_CODE, 4'h7);
      host_inst.issue(OP_CODE_SET, '0, BENCH_CODE, 4'hC, '0, 6'h00);
      `CHK("code_locked", 1'b1, host_inst.err_seen);
      lock_set(BOOL_OFF, BENCH_CODE, 4'hC);
      `CHK("old_code", 2'b11, {host_inst.err_seen, locked_o});
   endtask : t_adjust_code

   task automatic t_power;
      // image saved unlocked, so a factory fallback would show up as locked
      lock_set(BOOL_OFF, NEW_CODE, 4'h7);
      @(posedge clk_i);
      nv_valid_i    <= 1'b1;
      nv_locked_i   <= nv_locked_o;
      nv_code_i     <= nv_code_o;
      nv_code_len_i <= nv_code_len_o;
      nv_value_i    <= nv_value_o;
      nv_note_i     <= nv_note_o;
      nv_note_len_i <= nv_note_len_o;
      rst_n_i       <= 1'b0;
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(negedge clk_i);
      `CHK("pwr_lock", 1'b0, locked_o);
      `CHK("pwr_value", 32'h1234_5678, cal_value_o);
      host_inst.query(OP_NOTE_QRY, 0);
      `CHK("pwr_note", {CH_QUOTE, 16'h4142, CH_QUOTE}, host_inst.got[31:0]);
      lock_set(BOOL_ON, NEW_CODE, 4'h7);
      `CHK("pwr_code", 2'b01, {host_inst.err_seen, locked_o});
   endtask : t_power

   initial begin
      rst_n_i       = 1'b0;
      nv_valid_i    = 1'b0;
      nv_locked_i   = 1'b0;
      nv_code_i     = '0;
      nv_code_len_i = 4'h0;
      nv_value_i    = '0;
      nv_note_i     = '0;
      nv_note_len_i = 6'h00;
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_factory();
      t_lock();
      t_note();
      t_step_value();
      t_adjust_code();
      t_power();
      wrap_up();
   end
endmodule : csc_cal_ctrl_bench

/* File: test/csc_host_model.sv */
// host controller model: issues commands and gathers response bytes
`timescale 1ns/1ps
module csc_host_model
   import csc_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic          cmd_ready_i,
   input  wire logic          rsp_valid_i,
   input  wire logic [7:0]    rsp_data_i,
   input  wire logic          rsp_last_i,
   input  wire logic          err_i,
   input  wire logic          adjust_i,
   input  wire logic          nv_wr_i,
   output logic               cmd_valid_o,
   output csc_pkg::csc_op_t   cmd_op_o,
   output logic               arg_is_kw_o,
   output logic [31:0]        arg_num_o,
   output logic [95:0]        code_o,
   output logic [3:0]         code_len_o,
   output logic [319:0]       note_o,
   output logic [5:0]         note_len_o,
   output logic               rsp_ready_o,
   output logic               hang_o
);
   logic [63:0] got;
   int          nb;
   logic        err_seen;
   logic        adj_seen;
   logic        nv_seen;

   initial begin
      cmd_valid_o = 1'b0;
      cmd_op_o    = OP_LOCK_QRY;
      arg_is_kw_o = 1'b0;
      arg_num_o   = '0;
      code_o      = '0;
      code_len_o  = 4'h0;
      note_o      = '0;
      note_len_o  = 6'h00;
      rsp_ready_o = 1'b0;
      hang_o      = 1'b0;
   end

   // ---------------------------------------------------------------
   // command issue
   // ---------------------------------------------------------------
   // callers also pass illegal codes, steps, notes to check refusal
   task automatic issue(input csc_op_t op, input logic [31:0] num, input logic [95:0] code,
                        input logic [3:0] clen, input logic [319:0] note, input logic [5:0] nlen);
      int i;
      @(posedge clk_i);
      cmd_valid_o <= 1'b1;
      cmd_op_o    <= op;
      arg_is_kw_o <= ~arg_is_kw_o;
      arg_num_o   <= num;
      code_o      <= code;
      code_len_o  <= clen;
      note_o      <= note;
      note_len_o  <= nlen;
      for (i = 0; i < 40; i++) begin
         @(negedge clk_i);
         if (cmd_ready_i === 1'b1) break;
      end
      if (i == 40) hang_o = 1'b1;
      @(posedge clk_i);
      // released num, code and note fields show their inverse, never the last value
      cmd_valid_o <= 1'b0;
      arg_num_o   <= ~num;
      code_o      <= ~code;
      note_o      <= ~note;
      @(negedge clk_i);
      err_seen = err_i;
      adj_seen = adjust_i;
      nv_seen  = nv_wr_i;
   endtask : issue

   // stall holds the first bytes back to see them stand
   task automatic query(input csc_op_t op, input int stall);
      int i;
      got = '0;
      nb  = 0;
      issue(op, '0, '0, 4'h0, '0, 6'h00);
      for (i = 0; i < 64; i++) begin
         @(posedge clk_i);
         rsp_ready_o <= (i >= stall);
         @(negedge clk_i);
         if (rsp_valid_i === 1'b1 && rsp_ready_o === 1'b1) begin
            got = {got[55:0], rsp_data_i};
            nb++;
            if (rsp_last_i === 1'b1) break;
         end
      end
      if (i == 64) hang_o = 1'b1;
      @(posedge clk_i);
      rsp_ready_o <= 1'b0;
   endtask : query
endmodule : csc_host_model
